// >>> core/pio_consts.vh
// Constants for the port six and port seven parallel I/O block.
`ifndef PIO_CONSTS_VH
`define PIO_CONSTS_VH

// ==========================================================================
// Register indices and byte addresses
// ==========================================================================
`define PIO_P6_LATCH_IDX 20'h0ffd9
`define PIO_P7_LATCH_IDX 20'h0ffda
`define PIO_P6_DIR_IDX 20'h0ffe9
`define PIO_P7_DIR_IDX 20'h0ffea
`define PIO_P6_LATCH_ADDR 20'h3ff64
`define PIO_P7_LATCH_ADDR 20'h3ff68
`define PIO_P6_DIR_ADDR 20'h3ffa4
`define PIO_P7_DIR_ADDR 20'h3ffa8
`define PIO_P6_PULLUP_ADDR 20'h3ff00
`define PIO_MODE_ADDR 20'h3ff04

// ==========================================================================
// Reset values and fixed read values
// ==========================================================================
`define PIO_LATCH_RST 8'h00
`define PIO_DIR_RST 8'h00
`define PIO_P7_RST 5'h00
`define PIO_PULLUP_RST 8'h00
`define PIO_MODE_RST 2'h0
`define PIO_WO_READ 8'hff
`define PIO_P7_RSVD 3'h0

// ==========================================================================
// Field positions
// ==========================================================================
`define PIO_P7_LSB 3
`define PIO_MODE_SLEEP 0
`define PIO_MODE_STANDBY 1

`endif

// >>> core/pio_ports.v
// Port six and port seven parallel I/O block with an APB register slave.
`include "pio_consts.vh"

// Overview of operation
// - Port six read returns latch bit where direction bit is one.
// - Port six read returns the pin level where direction bit is zero.
// - Reset clears the port six data latch to zero.
// - Port six direction bit one makes an output, zero an input.
// - Reset clears port six direction, all pins start as inputs.
// - Port six direction is write-only and reads as all ones.
// - Port six floats in reset, holds in sleep unless standby is set, standby floats unless pulled up.
// - Port seven data bits two to zero read zero and ignore writes.
// - Port seven read returns latch bit where direction bit is one.
// - Port seven read returns the pin level where direction bit is zero.
// - Port seven direction bits seven to three select output or input.
// - Reset clears the port seven data latch to zero.
// - Reset clears port seven direction, all pins start as inputs.
// - Port seven direction is write-only and reads as all ones.
module pio_ports (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [19:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [7:0] port_six_pin_in,
   output reg [7:0] port_six_pin_out,
   output reg [7:0] port_six_pin_oe,
   output reg [7:0] port_six_pullup_on,
   input wire [4:0] port_seven_pin_in,
   output reg [4:0] port_seven_pin_out,
   output reg [4:0] port_seven_pin_oe
);

   // =======================================================================
   // Register state
   // =======================================================================
   reg [7:0] p6_latch_reg;
   reg [7:0] p6_dir_reg;
   reg [7:0] p6_pullup_reg;
   reg [4:0] p7_latch_reg;
   reg [4:0] p7_dir_reg;
   reg [1:0] mode_reg;

   wire setup_phase;
   wire wr_commit;
   wire sleep_mode;
   wire standby_mode;
   wire [7:0] p6_read;
   wire [7:0] p7_read;
   wire [7:0] p6_pull_active;
   wire [4:0] p7_pins_read;

   assign setup_phase = psel & ~penable;
   assign wr_commit = psel & penable & pready & pwrite;
   assign sleep_mode = mode_reg[`PIO_MODE_SLEEP];
   assign standby_mode = mode_reg[`PIO_MODE_STANDBY];

   // Reserved low bits of port seven have no storage and always read zero.
   assign p7_read = {p7_pins_read, `PIO_P7_RSVD};

   // =======================================================================
   // Pin slices: read mix and pull-up qualifier, one per pin
   // =======================================================================
   // Port six, pins seven down to zero.
   pio_pin_slice six_slice_0 (
      .dir_bit(p6_dir_reg[0]),
      .latch_bit(p6_latch_reg[0]),
      .pullup_bit(p6_pullup_reg[0]),
      .pin_bit(port_six_pin_in[0]),
      .read_bit(p6_read[0]),
      .pull_bit(p6_pull_active[0])
   );

   pio_pin_slice six_slice_1 (
      .dir_bit(p6_dir_reg[1]),
      .latch_bit(p6_latch_reg[1]),
      .pullup_bit(p6_pullup_reg[1]),
      .pin_bit(port_six_pin_in[1]),
      .read_bit(p6_read[1]),
      .pull_bit(p6_pull_active[1])
   );

   pio_pin_slice six_slice_2 (
      .dir_bit(p6_dir_reg[2]),
      .latch_bit(p6_latch_reg[2]),
      .pullup_bit(p6_pullup_reg[2]),
      .pin_bit(port_six_pin_in[2]),
      .read_bit(p6_read[2]),
      .pull_bit(p6_pull_active[2])
   );

   pio_pin_slice six_slice_3 (
      .dir_bit(p6_dir_reg[3]),
      .latch_bit(p6_latch_reg[3]),
      .pullup_bit(p6_pullup_reg[3]),
      .pin_bit(port_six_pin_in[3]),
      .read_bit(p6_read[3]),
      .pull_bit(p6_pull_active[3])
   );

   pio_pin_slice six_slice_4 (
      .dir_bit(p6_dir_reg[4]),
      .latch_bit(p6_latch_reg[4]),
      .pullup_bit(p6_pullup_reg[4]),
      .pin_bit(port_six_pin_in[4]),
      .read_bit(p6_read[4]),
      .pull_bit(p6_pull_active[4])
   );

   pio_pin_slice six_slice_5 (
      .dir_bit(p6_dir_reg[5]),
      .latch_bit(p6_latch_reg[5]),
      .pullup_bit(p6_pullup_reg[5]),
      .pin_bit(port_six_pin_in[5]),
      .read_bit(p6_read[5]),
      .pull_bit(p6_pull_active[5])
   );

   pio_pin_slice six_slice_6 (
      .dir_bit(p6_dir_reg[6]),
      .latch_bit(p6_latch_reg[6]),
      .pullup_bit(p6_pullup_reg[6]),
      .pin_bit(port_six_pin_in[6]),
      .read_bit(p6_read[6]),
      .pull_bit(p6_pull_active[6])
   );

   pio_pin_slice six_slice_7 (
      .dir_bit(p6_dir_reg[7]),
      .latch_bit(p6_latch_reg[7]),
      .pullup_bit(p6_pullup_reg[7]),
      .pin_bit(port_six_pin_in[7]),
      .read_bit(p6_read[7]),
      .pull_bit(p6_pull_active[7])
   );

   // Port seven, pins seven down to three; bit zero of each vector is pin three.
   pio_pin_slice seven_slice_0 (
      .dir_bit(p7_dir_reg[0]),
      .latch_bit(p7_latch_reg[0]),
      .pullup_bit(1'b0),
      .pin_bit(port_seven_pin_in[0]),
      .read_bit(p7_pins_read[0]),
      .pull_bit()
   );

   pio_pin_slice seven_slice_1 (
      .dir_bit(p7_dir_reg[1]),
      .latch_bit(p7_latch_reg[1]),
      .pullup_bit(1'b0),
      .pin_bit(port_seven_pin_in[1]),
      .read_bit(p7_pins_read[1]),
      .pull_bit()
   );

   pio_pin_slice seven_slice_2 (
      .dir_bit(p7_dir_reg[2]),
      .latch_bit(p7_latch_reg[2]),
      .pullup_bit(1'b0),
      .pin_bit(port_seven_pin_in[2]),
      .read_bit(p7_pins_read[2]),
      .pull_bit()
   );

   pio_pin_slice seven_slice_3 (
      .dir_bit(p7_dir_reg[3]),
      .latch_bit(p7_latch_reg[3]),
      .pullup_bit(1'b0),
      .pin_bit(port_seven_pin_in[3]),
      .read_bit(p7_pins_read[3]),
      .pull_bit()
   );

   pio_pin_slice seven_slice_4 (
      .dir_bit(p7_dir_reg[4]),
      .latch_bit(p7_latch_reg[4]),
      .pullup_bit(1'b0),
      .pin_bit(port_seven_pin_in[4]),
      .read_bit(p7_pins_read[4]),
      .pull_bit()
   );

   // =======================================================================
   // APB slave: answer one cycle into the access phase
   // =======================================================================
   // The answer freezes with clk_en as well, so the master must run on the same enable.
   // A setup cycle that falls on a disabled edge is never answered.
   reg [31:0] rdata_next;
   reg err_next;

   always @* begin
      rdata_next = 32'h00000000;
      err_next = 1'b0;
      case (paddr)
         `PIO_P6_LATCH_ADDR: rdata_next = {24'h000000, p6_read};
         `PIO_P6_DIR_ADDR: rdata_next = {24'h000000, `PIO_WO_READ};
         `PIO_P7_LATCH_ADDR: rdata_next = {24'h000000, p7_read};
         `PIO_P7_DIR_ADDR: rdata_next = {24'h000000, `PIO_WO_READ};
         `PIO_P6_PULLUP_ADDR: rdata_next = {24'h000000, p6_pullup_reg};
         `PIO_MODE_ADDR: rdata_next = {30'h00000000, mode_reg};
         default: err_next = 1'b1;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         if (setup_phase) begin
            pready <= 1'b1;
            pslverr <= err_next;
            prdata <= pwrite ? 32'h00000000 : rdata_next;
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // =======================================================================
   // Register writes, taken at the completing access edge
   // =======================================================================
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p6_latch_reg <= `PIO_LATCH_RST;
         p6_dir_reg <= `PIO_DIR_RST;
         p7_latch_reg <= `PIO_P7_RST;
         p7_dir_reg <= `PIO_P7_RST;
         p6_pullup_reg <= `PIO_PULLUP_RST;
         mode_reg <= `PIO_MODE_RST;
      end else if (clk_en && wr_commit) begin
         case (paddr)
            `PIO_P6_LATCH_ADDR: p6_latch_reg <= pwdata[7:0];
            `PIO_P6_DIR_ADDR: p6_dir_reg <= pwdata[7:0];
            // Bits two to zero have no storage, so writes to them vanish.
            `PIO_P7_LATCH_ADDR: p7_latch_reg <= pwdata[7:`PIO_P7_LSB];
            `PIO_P7_DIR_ADDR: p7_dir_reg <= pwdata[7:`PIO_P7_LSB];
            `PIO_P6_PULLUP_ADDR: p6_pullup_reg <= pwdata[7:0];
            `PIO_MODE_ADDR: mode_reg <= pwdata[1:0];
            default: mode_reg <= mode_reg;
         endcase
      end
   end

   // =======================================================================
   // Pin drivers
   // =======================================================================
   // Reset leaves every pin undriven; sleep freezes the port six pins as they were unless standby is also set.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_six_pin_out <= 8'h00;
         port_six_pin_oe <= 8'h00;
         port_six_pullup_on <= 8'h00;
         port_seven_pin_out <= 5'h00;
         port_seven_pin_oe <= 5'h00;
      end else if (clk_en) begin
         // Port seven has no low-power behaviour and always follows its registers.
         port_seven_pin_out <= p7_latch_reg;
         port_seven_pin_oe <= p7_dir_reg;
         port_six_pullup_on <= p6_pull_active;
         if (standby_mode) begin
            // Only pulled-up pins drive high, all others float.
            port_six_pin_out <= p6_pull_active;
            port_six_pin_oe <= p6_pull_active;
         end else if (!sleep_mode) begin
            port_six_pin_out <= p6_latch_reg;
            port_six_pin_oe <= p6_dir_reg;
         end
      end
   end

endmodule // pio_ports

// ==========================================================================
// One pin slice
// ==========================================================================
// Combinational per-pin logic; the owning block registers everything it drives out.
module pio_pin_slice (
   input wire dir_bit,
   input wire latch_bit,
   input wire pullup_bit,
   input wire pin_bit,
   output wire read_bit,
   output wire pull_bit
);

   // A driving pin reads back its latch, a listening pin reads the pin itself.
   assign read_bit = dir_bit ? latch_bit : pin_bit;

   // The pull-up only acts on a listening pin.
   assign pull_bit = ~dir_bit & pullup_bit;

endmodule // pio_pin_slice

// >>> verif/pio_sva.sv
// Assertion checker for the port six and port seven block.
`include "pio_consts.vh"
module pio_sva (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [19:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [7:0] port_six_pin_oe,
   input wire [4:0] port_seven_pin_in,
   input wire [4:0] port_seven_pin_out,
   input wire [4:0] port_seven_pin_oe
);
   wire rd_done = psel && penable && pready && !pwrite;
   wire wr_done = psel && penable && pready && pwrite && clk_en;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // Checks
   chk_ready_next: assert property (psel && !penable && clk_en |=> pready) else $error("no answer after setup");
   chk_six_dir_ones: assert property (rd_done && paddr == `PIO_P6_DIR_ADDR |-> prdata == 32'h000000ff)
      else $error("port six direction read wrong");
   chk_seven_dir_ones: assert property (rd_done && paddr == `PIO_P7_DIR_ADDR |-> prdata == 32'h000000ff)
      else $error("port seven direction read wrong");
   chk_seven_rsvd: assert property (rd_done && paddr == `PIO_P7_LATCH_ADDR |-> prdata[2:0] == 3'h0)
      else $error("reserved bits not zero");
   chk_seven_read: assert property (rd_done && paddr == `PIO_P7_LATCH_ADDR |-> prdata[7:3] ==
      ((port_seven_pin_oe & port_seven_pin_out) | (~port_seven_pin_oe & $past(port_seven_pin_in))))
      else $error("port seven read mix wrong");
   chk_seven_oe_set: assert property (wr_done && paddr == `PIO_P7_DIR_ADDR ##1 clk_en |=>
      port_seven_pin_oe == $past(pwdata[7:3], 2)) else $error("port seven enable not updated");
   chk_seven_out_set: assert property (wr_done && paddr == `PIO_P7_LATCH_ADDR ##1 clk_en |=>
      port_seven_pin_out == $past(pwdata[7:3], 2)) else $error("port seven drive not updated");
   chk_reset_float: assert property ($rose(presetn) |-> port_six_pin_oe == 8'h00 && port_seven_pin_oe == 5'h00)
      else $error("pins driven after reset");
   cover property (rd_done && paddr == `PIO_P6_LATCH_ADDR);
   cover property (wr_done && paddr == `PIO_P7_DIR_ADDR);
   cover property (psel && penable && pready && pslverr);
endmodule // pio_sva
bind pio_ports pio_sva pio_sva_inst (.*);

// >>> verif/pio_board.sv
// Board model that drives the port pins from outside.
module pio_board (
   input logic fight,
   input logic [7:0] ext6,
   input logic [4:0] ext7,
   input logic [7:0] six_out,
   input logic [7:0] six_oe,
   output logic [7:0] six_in,
   input logic [4:0] seven_out,
   input logic [4:0] seven_oe,
   output logic [4:0] seven_in
);
   // With fight set the board overpowers every pin, so reads show whether the latch or the pin is used.
   wire [7:0] d6 = fight ? 8'h00 : six_oe;
   wire [4:0] d7 = fight ? 5'h00 : seven_oe;
   assign six_in = (d6 & six_out) | (~d6 & ext6);
   assign seven_in = (d7 & seven_out) | (~d7 & ext7);
endmodule // pio_board

// >>> verif/tb_top.sv
// Self-checking bench for the port six and port seven block.
`include "pio_consts.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fight = 0, clk_en = 1, pready, pslverr, err;
   logic [19:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdata;
   logic [7:0] p6i, p6o, p6e, pu, ext6 = 0;
   logic [4:0] p7i, p7o, p7e, ext7 = 0;
   int n_mismatch = 0, total_checks = 0;
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   pio_ports pio_ports_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_six_pin_in(p6i), .port_six_pin_out(p6o), .port_six_pin_oe(p6e), .port_six_pullup_on(pu),
      .port_seven_pin_in(p7i), .port_seven_pin_out(p7o), .port_seven_pin_oe(p7e));
   pio_board pio_board_inst (.fight(fight), .ext6(ext6), .ext7(ext7), .six_out(p6o), .six_oe(p6e), .six_in(p6i),
      .seven_out(p7o), .seven_oe(p7e), .seven_in(p7i));
   task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [19:0] a, input logic [7:0] e, input string n);
      xfer(1'b0, a, 32'h0);
      `CHK(n, {24'h0, e}, rdata)
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      finish_test;
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      ext6 <= 8'ha5;
      ext7 <= 5'h15;
      @(posedge pclk);
      `CHK("oe6", 8'h00, p6e)
      rd(`PIO_P6_LATCH_ADDR, 8'ha5, "p6 pins");
      rd(`PIO_P7_LATCH_ADDR, 8'ha8, "p7 pins");
      rd(`PIO_P6_DIR_ADDR, 8'hff, "p6 dir");
      rd(`PIO_P7_DIR_ADDR, 8'hff, "p7 dir");
      xfer(1'b0, 20'h00010, 32'h0);
      `CHK("slverr", 1'b1, err)
      $display("test reset done");
      fight <= 1'b1;
      xfer(1'b1, `PIO_P6_LATCH_ADDR, 32'h3c);
      xfer(1'b1, `PIO_P6_DIR_ADDR, 32'hf0);
      fork
         xfer(1'b1, `PIO_P7_LATCH_ADDR, 32'hffffffff);
         begin
            do @(posedge pclk); while (!(psel && penable && pready === 1'b1));
            clk_en <= 1'b0;
            repeat (2) @(posedge pclk);
            `CHK("frozen out7", 5'h00, p7o)
            clk_en <= 1'b1;
            repeat (2) @(posedge pclk);
            `CHK("out7", 5'h1f, p7o)
         end
      join
      xfer(1'b1, `PIO_P7_DIR_ADDR, 32'hc8);
      @(posedge pclk);
      `CHK("oe6", 8'hf0, p6e)
      `CHK("out6", 8'h3c, p6o)
      `CHK("oe7", 5'h19, p7e)
      rd(`PIO_P6_LATCH_ADDR, 8'h35, "p6 mixed");
      rd(`PIO_P7_LATCH_ADDR, 8'he8, "p7 mixed");
      $display("test mixed done");
      presetn <= 1'b0;
      @(posedge pclk) presetn <= 1'b1;
      xfer(1'b1, `PIO_P6_DIR_ADDR, 32'hff);
      xfer(1'b1, `PIO_P7_DIR_ADDR, 32'hf8);
      rd(`PIO_P6_LATCH_ADDR, 8'h00, "p6 cleared");
      rd(`PIO_P7_LATCH_ADDR, 8'h00, "p7 cleared");
      xfer(1'b1, `PIO_P7_LATCH_ADDR, 32'h57);
      rd(`PIO_P7_LATCH_ADDR, 8'h50, "p7 latch");
      xfer(1'b1, `PIO_MODE_ADDR, 32'h1);
      xfer(1'b1, `PIO_P6_LATCH_ADDR, 32'h5a);
      @(posedge pclk);
      `CHK("sleep out6", 8'h00, p6o)
      `CHK("sleep oe6", 8'hff, p6e)
      rd(`PIO_P6_LATCH_ADDR, 8'h5a, "p6 sleep latch");
      xfer(1'b1, `PIO_P6_DIR_ADDR, 32'h0);
      xfer(1'b1, `PIO_P6_PULLUP_ADDR, 32'h0f);
      xfer(1'b1, `PIO_MODE_ADDR, 32'h2);
      repeat (2) @(posedge pclk);
      `CHK("standby oe6", 8'h0f, p6e)
      `CHK("standby out6", 8'h0f, p6o)
      `CHK("pullup on", 8'h0f, pu)
      $display("test clear and standby done");
      finish_test;
   end
endmodule // tb_top
